/* rtl/dtm_pkg.sv */
package dtm_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CFG   = 12'h000;
	localparam logic [11:0] ADDR_MODE1 = 12'h004;
	localparam logic [11:0] ADDR_MODE2 = 12'h008;
	localparam logic [11:0] ADDR_CTL   = 12'h00c;
	localparam logic [11:0] ADDR_IMR   = 12'h018;
	localparam logic [11:0] ADDR_RIS   = 12'h01c;
	localparam logic [11:0] ADDR_MIS   = 12'h020;
	localparam logic [11:0] ADDR_ICR   = 12'h024;

	// ------------------------------------------------------------
	// Reset values and writable bit masks
	// ------------------------------------------------------------
	localparam logic [2:0]  CFG_RST   = 3'h0;
	localparam logic [3:0]  MODE_RST  = 4'h0;
	localparam logic [14:0] CTL_RST   = 15'h0000;
	localparam logic [10:0] IRQ_RST   = 11'h000;
	localparam logic [14:0] CTL_WMASK = 15'h6f7f;
	localparam logic [10:0] IRQ_WMASK = 11'h70f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_AMS   = 3;
	localparam int MODE_CMR   = 2;
	localparam int CTL_STRIDE = 8;
	localparam int CTL_EN     = 0;
	localparam int CTL_STALL  = 1;
	localparam int CTL_EVT    = 2;
	localparam int CTL_RTC    = 4;
	localparam int CTL_TRIG   = 5;
	localparam int CTL_INV    = 6;
	localparam int IRQ_STRIDE = 8;
	localparam int IRQ_TO     = 0;
	localparam int IRQ_CM     = 1;
	localparam int IRQ_CE     = 2;
	localparam int IRQ_RTC    = 3;
	localparam int CFG_SPLIT  = 2;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] CFG_WIDE = 3'h0;
	localparam logic [2:0] CFG_RTC  = 3'h1;

	typedef enum logic [1:0] {
		MR_RSVD     = 2'h0,
		MR_ONESHOT  = 2'h1,
		MR_PERIODIC = 2'h2,
		MR_CAPTURE  = 2'h3
	} dtm_mr_t;

	typedef enum logic [1:0] {
		EDGE_POS  = 2'h0,
		EDGE_NEG  = 2'h1,
		EDGE_RSVD = 2'h2,
		EDGE_BOTH = 2'h3
	} dtm_edge_t;

endpackage : dtm_pkg

/* rtl/dtm_mode_decode.sv */
`timescale 1ns/10ps
module dtm_mode_decode (
	input  wire logic [3:0] mode,
	output logic            oneshot,
	output logic            periodic,
	output logic            capture,
	output logic            edge_time,
	output logic            pwm
);
	import dtm_pkg::*;

	dtm_mr_t mr;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// The reserved mode value decodes to no mode at all.
	always_comb begin
		mr        = dtm_mr_t'(mode[1:0]);
		oneshot   = !mode[MODE_AMS] && (mr == MR_ONESHOT);
		periodic  = !mode[MODE_AMS] && (mr == MR_PERIODIC);
		capture   = !mode[MODE_AMS] && (mr == MR_CAPTURE);
		edge_time = capture && mode[MODE_CMR];
		pwm       = mode[MODE_AMS] && !mode[MODE_CMR]
			&& (mr == MR_PERIODIC);
	end

endmodule : dtm_mode_decode

/* rtl/dtm_regs.sv */
// Operation
// - Second mode bit 3: 0 selects capture, 1 selects PWM.
// - Second mode bit 2: 0 counts edges, 1 time-stamps edges.
// - Mode field 1:0: reserved, one-shot, periodic, capture.
// - Mode field meaning depends on unit configuration bits 2:0.
// - In 32-bit configuration second mode register is ignored.
// - PWM level bits 14 and 6 invert the PWM output when set.
// - Trigger enables bits 13 and 5 gate each ADC trigger output.
// - Edge fields 11:10 and 3:2: positive, negative, reserved, both.
// - Stall enables bits 9 and 1 let a timer stall on halt.
// - Control bit 4 enables real-time-clock counting.
// - Enable bits 8 and 0 start counting or arm capture.
// - Mask bit 1 enables an interrupt source, 0 disables it.
// - Mask bits 10,9,8 second; 3 clock; 2,1,0 first timer.
// - Configuration 0 wide, 1 clock counter, 4 to 7 split, 2,3 reserved.
// - Raw status sets regardless of mask; masked status shows enabled ones.
`timescale 1ns/10ps
module dtm_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  timeout_evt,
	input  wire logic [1:0]  match_evt,
	input  wire logic        rtc_evt,
	input  wire logic [1:0]  cap_pin,
	input  wire logic [1:0]  pwm_raw,
	input  wire logic [1:0]  trig_raw,
	input  wire logic        debug_halt,
	output logic             irq,
	output logic      [1:0]  tmr_run,
	output logic      [1:0]  tmr_oneshot,
	output logic      [1:0]  tmr_periodic,
	output logic      [1:0]  tmr_capture,
	output logic      [1:0]  tmr_edge_time,
	output logic      [1:0]  tmr_pwm,
	output logic      [1:0]  tmr_stall,
	output logic      [1:0]  cap_event,
	output logic      [1:0]  pwm_out,
	output logic      [1:0]  adc_trigger,
	output logic             wide_mode,
	output logic             rtc_count_en
);
	import dtm_pkg::*;

	logic [2:0]  cfg_q;
	logic [3:0]  mode_q [2];
	logic [3:0]  eff_mode [2];
	logic [14:0] ctl_q;
	logic [10:0] imr_q;
	logic [10:0] ris_q;
	logic [10:0] ris_d;
	logic [10:0] set_vec;
	logic [10:0] clr_vec;
	logic [1:0]  cap_prev_q;
	logic [1:0]  edge_hit;
	logic [1:0]  dec_one;
	logic [1:0]  dec_per;
	logic [1:0]  dec_cap;
	logic [1:0]  dec_et;
	logic [1:0]  dec_pwm;
	logic        wide_d;
	logic        split_d;
	logic        acc_wr;
	logic        setup;
	logic [31:0] rd_d;
	logic        err_d;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// Read data is latched in the setup cycle so prdata comes from a
	// flop; a status event in the access cycle shows on the next read.
	assign setup  = psel && !penable;
	assign acc_wr = psel && penable && pready && pwrite;

	always_comb begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		case (paddr)
			ADDR_CFG:   rd_d = {29'h0, cfg_q};
			ADDR_MODE1: rd_d = {28'h0, mode_q[0]};
			ADDR_MODE2: rd_d = {28'h0, mode_q[1]};
			ADDR_CTL:   rd_d = {17'h0, ctl_q};
			ADDR_IMR:   rd_d = {21'h0, imr_q};
			ADDR_RIS:   rd_d = {21'h0, ris_q};
			ADDR_MIS:   rd_d = {21'h0, ris_q & imr_q};
			ADDR_ICR:   rd_d = 32'h0000_0000;
			default:    err_d = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= err_d;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration and mode registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q     <= CFG_RST;
			mode_q[0] <= MODE_RST;
			mode_q[1] <= MODE_RST;
		end else if (acc_wr) begin
			if (paddr == ADDR_CFG)
				cfg_q <= pwdata[2:0];
			if (paddr == ADDR_MODE1)
				mode_q[0] <= pwdata[3:0];
			if (paddr == ADDR_MODE2)
				mode_q[1] <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Control and mask registers
	// ------------------------------------------------------------
	// Reserved bits are not stored and read as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= CTL_RST;
			imr_q <= IRQ_RST;
		end else if (acc_wr) begin
			if (paddr == ADDR_CTL)
				ctl_q <= pwdata[14:0] & CTL_WMASK;
			if (paddr == ADDR_IMR)
				imr_q <= pwdata[10:0] & IRQ_WMASK;
		end
	end

	// ------------------------------------------------------------
	// Unit configuration decode
	// ------------------------------------------------------------
	// Reserved configurations 2 and 3 are neither wide nor split,
	// so no timer runs in them.
	assign wide_d  = (cfg_q == CFG_WIDE) || (cfg_q == CFG_RTC);
	assign split_d = cfg_q[CFG_SPLIT];

	assign eff_mode[0] = mode_q[0];
	assign eff_mode[1] = wide_d ? mode_q[0] : mode_q[1];

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	assign set_vec[7:4]   = 4'h0;
	assign set_vec[IRQ_RTC] = rtc_evt;
	assign set_vec[IRQ_STRIDE+IRQ_CE] = cap_event[1];
	assign clr_vec = (acc_wr && paddr == ADDR_ICR) ?
		(pwdata[10:0] & IRQ_WMASK) : 11'h000;
	// A new event wins over a clear in the same cycle.
	assign ris_d = (ris_q & ~clr_vec) | set_vec;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ris_q <= IRQ_RST;
			irq   <= 1'b0;
		end else begin
			ris_q <= ris_d;
			irq   <= |(ris_q & imr_q);
		end
	end

	// ------------------------------------------------------------
	// Per-timer logic
	// ------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_tmr
		logic [1:0] esel;
		logic       rise;
		logic       fall;

		dtm_mode_decode u_dec (
			.mode      (eff_mode[i]),
			.oneshot   (dec_one[i]),
			.periodic  (dec_per[i]),
			.capture   (dec_cap[i]),
			.edge_time (dec_et[i]),
			.pwm       (dec_pwm[i])
		);

		if (i == 0) begin : g_set
			assign set_vec[IRQ_CE] = cap_event[0];
		end

		assign set_vec[IRQ_STRIDE*i+IRQ_TO] = timeout_evt[i];
		assign set_vec[IRQ_STRIDE*i+IRQ_CM] = match_evt[i];

		assign esel = ctl_q[CTL_STRIDE*i+CTL_EVT+:2];
		assign rise = cap_pin[i] && !cap_prev_q[i];
		assign fall = !cap_pin[i] && cap_prev_q[i];

		always_comb begin
			case (dtm_edge_t'(esel))
				EDGE_POS:  edge_hit[i] = rise;
				EDGE_NEG:  edge_hit[i] = fall;
				EDGE_BOTH: edge_hit[i] = rise || fall;
				default:   edge_hit[i] = 1'b0;
			endcase
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tmr_run[i]       <= 1'b0;
				tmr_oneshot[i]   <= 1'b0;
				tmr_periodic[i]  <= 1'b0;
				tmr_capture[i]   <= 1'b0;
				tmr_edge_time[i] <= 1'b0;
				tmr_pwm[i]       <= 1'b0;
			end else begin
				// The second timer idles in the wide configurations.
				tmr_run[i] <= ctl_q[CTL_STRIDE*i+CTL_EN]
					&& (i == 0 ? (wide_d || split_d)
					: split_d);
				tmr_oneshot[i]   <= dec_one[i];
				tmr_periodic[i]  <= dec_per[i];
				tmr_capture[i]   <= dec_cap[i];
				tmr_edge_time[i] <= dec_et[i];
				tmr_pwm[i]       <= dec_pwm[i];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cap_prev_q[i]  <= 1'b0;
				cap_event[i]   <= 1'b0;
				tmr_stall[i]   <= 1'b0;
				pwm_out[i]     <= 1'b0;
				adc_trigger[i] <= 1'b0;
			end else begin
				cap_prev_q[i] <= cap_pin[i];
				cap_event[i]  <= edge_hit[i] && tmr_run[i]
					&& tmr_capture[i];
				tmr_stall[i]  <= debug_halt
					&& ctl_q[CTL_STRIDE*i+CTL_STALL];
				pwm_out[i]    <= pwm_raw[i]
					^ ctl_q[CTL_STRIDE*i+CTL_INV];
				adc_trigger[i] <= trig_raw[i]
					&& ctl_q[CTL_STRIDE*i+CTL_TRIG];
			end
		end
	end

	// ------------------------------------------------------------
	// Unit-wide outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wide_mode    <= 1'b0;
			rtc_count_en <= 1'b0;
		end else begin
			wide_mode    <= wide_d;
			rtc_count_en <= ctl_q[CTL_RTC] && cfg_q == CFG_RTC;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_alt_pwm;
		tmr_pwm[1] |-> $past(eff_mode[1][MODE_AMS]) && !tmr_capture[1];
	endproperty
	a_alt_pwm: assert property (p_alt_pwm)
		else $error("PWM flagged without alternate mode bit.");

	property p_edge_time;
		tmr_edge_time[1] |-> tmr_capture[1]
			&& $past(eff_mode[1][MODE_CMR]);
	endproperty
	a_edge_time: assert property (p_edge_time)
		else $error("Edge time flagged outside capture style.");

	property p_mode_rsvd;
		$past(eff_mode[0][1:0]) == MR_RSVD
		|-> !(tmr_oneshot[0] || tmr_periodic[0] || tmr_capture[0]);
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd)
		else $error("Reserved mode decoded to a mode.");

	property p_wide_ignore;
		$past(wide_d) |-> !tmr_run[1]
			&& tmr_oneshot[1] == tmr_oneshot[0]
			&& tmr_capture[1] == tmr_capture[0];
	endproperty
	a_wide_ignore: assert property (p_wide_ignore)
		else $error("Second mode used in wide configuration.");

	property p_invert;
		pwm_out[0] == $past(pwm_raw[0] ^ ctl_q[CTL_INV]);
	endproperty
	a_invert: assert property (p_invert)
		else $error("PWM output level wrong.");

	property p_trigger;
		adc_trigger[1] |-> $past(ctl_q[CTL_STRIDE+CTL_TRIG]);
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("Trigger passed while disabled.");

	property p_edge_sel;
		cap_event[1] |->
			$past(ctl_q[CTL_STRIDE+CTL_EVT+:2]) != EDGE_RSVD;
	endproperty
	a_edge_sel: assert property (p_edge_sel)
		else $error("Capture event under reserved edge select.");

	property p_stall;
		tmr_stall[0] == $past(debug_halt && ctl_q[CTL_STALL]);
	endproperty
	a_stall: assert property (p_stall)
		else $error("Stall does not follow its enable.");

	property p_rtc;
		rtc_count_en |-> $past(ctl_q[CTL_RTC]) && $past(cfg_q) == CFG_RTC;
	endproperty
	a_rtc: assert property (p_rtc)
		else $error("Clock counting without enable.");

	property p_run;
		tmr_run[0] |-> $past(ctl_q[CTL_EN]);
	endproperty
	a_run: assert property (p_run)
		else $error("Timer runs while disabled.");

	property p_sticky;
		timeout_evt[0] |=> ris_q[IRQ_TO] ##1 irq == imr_q[IRQ_TO] ||
			$past(|(ris_q & imr_q));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("Event did not set raw status.");

	property p_irq;
		irq == $past(|(ris_q & imr_q));
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt output disagrees with status.");

	c_pwm:   cover property (tmr_pwm[1] && tmr_run[1]);
	c_cap:   cover property (cap_event[1] ##1 irq);
	c_clear: cover property (acc_wr && paddr == ADDR_ICR && |set_vec);

endmodule : dtm_regs

/* testbench/test_dual_timer_mode_control_regs.sv */
`timescale 1ns/10ps
module test_dual_timer_mode_control_regs;
	import dtm_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  timeout_evt, match_evt, cap_pin, pwm_raw, trig_raw;
	logic        rtc_evt, debug_halt, irq, wide_mode, rtc_count_en;
	logic [1:0]  tmr_run, tmr_oneshot, tmr_periodic, tmr_capture;
	logic [1:0]  tmr_edge_time, tmr_pwm, tmr_stall, cap_event;
	logic [1:0]  pwm_out, adc_trigger;
	int          failures, tests_run;

	dtm_regs i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timeout_evt(timeout_evt),
		.match_evt(match_evt), .rtc_evt(rtc_evt), .cap_pin(cap_pin),
		.pwm_raw(pwm_raw), .trig_raw(trig_raw), .debug_halt(debug_halt),
		.irq(irq), .tmr_run(tmr_run), .tmr_oneshot(tmr_oneshot),
		.tmr_periodic(tmr_periodic), .tmr_capture(tmr_capture),
		.tmr_edge_time(tmr_edge_time), .tmr_pwm(tmr_pwm),
		.tmr_stall(tmr_stall), .cap_event(cap_event), .pwm_out(pwm_out),
		.adc_trigger(adc_trigger), .wide_mode(wide_mode),
		.rtc_count_en(rtc_count_en)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_sim;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Reads are taken in the edge's active region, before the flops move.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk

	task automatic settle;
		repeat (3) @(posedge pclk);
	endtask : settle

	task automatic pulse(input logic [1:0] t, input logic [1:0] m,
		input logic r);
		@(posedge pclk);
		timeout_evt <= t;
		match_evt <= m;
		rtc_evt <= r;
		@(posedge pclk);
		timeout_evt <= 2'h0;
		match_evt <= 2'h0;
		rtc_evt <= 1'b0;
	endtask : pulse

	task automatic cap_cnt(input logic lvl, input int e);
		int c;
		@(posedge pclk);
		cap_pin[1] <= lvl;
		c = 0;
		repeat (4) begin
			@(posedge pclk);
			if (cap_event[1] === 1'b1) c++;
		end
		chk("cap_event", e, c);
	endtask : cap_cnt

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rdchk("cfg", ADDR_CFG, 32'h0);
		rdchk("mode2", ADDR_MODE2, 32'h0);
		rdchk("ctl", ADDR_CTL, 32'h0);
		rdchk("imr", ADDR_IMR, 32'h0);
		chk("irq", 32'h0, irq);
	endtask : t_reset

	task automatic t_modes;
		logic [3:0] v [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'ha};
		logic [4:0] x [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h06, 5'h01};
		logic [4:0] k [6] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h07};
		logic [4:0] g;
		apb(1'b1, ADDR_CFG, 32'h4);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ADDR_MODE2, {28'h0, v[i]});
			settle();
			g = {tmr_oneshot[1], tmr_periodic[1], tmr_capture[1],
				tmr_edge_time[1], tmr_pwm[1]};
			chk("mode2 flags", x[i] & k[i], g & k[i]);
		end
		rdchk("mode2", ADDR_MODE2, 32'ha);
	endtask : t_modes

	task automatic t_config;
		apb(1'b1, ADDR_CFG, 32'h0);
		apb(1'b1, ADDR_MODE1, 32'h1);
		apb(1'b1, ADDR_MODE2, 32'h2);
		apb(1'b1, ADDR_CTL, 32'h101);
		settle();
		chk("wide oneshot", 32'h3, tmr_oneshot);
		chk("wide periodic", 32'h0, tmr_periodic);
		chk("wide run", 32'h1, tmr_run);
		chk("wide_mode", 32'h1, wide_mode);
		apb(1'b1, ADDR_CFG, 32'h7);
		settle();
		chk("split run", 32'h3, tmr_run);
		chk("split periodic", 32'h2, tmr_periodic);
		apb(1'b1, ADDR_CFG, 32'h2);
		settle();
		chk("rsvd run", 32'h0, tmr_run);
		apb(1'b1, ADDR_CTL, 32'h10);
		apb(1'b1, ADDR_CFG, 32'h1);
		settle();
		chk("rtc_count_en", 32'h1, rtc_count_en);
		apb(1'b1, ADDR_CTL, 32'h0);
		settle();
		chk("rtc off", 32'h0, rtc_count_en);
	endtask : t_config

	task automatic t_ctl;
		apb(1'b1, ADDR_CTL, 32'hffffffff);
		rdchk("ctl mask", ADDR_CTL, 32'h6f7f);
		@(posedge pclk);
		pwm_raw <= 2'h1;
		trig_raw <= 2'h3;
		debug_halt <= 1'b1;
		apb(1'b1, ADDR_CTL, 32'h6262);
		settle();
		chk("pwm_out", 32'h2, pwm_out);
		chk("adc_trigger", 32'h3, adc_trigger);
		chk("tmr_stall", 32'h3, tmr_stall);
		apb(1'b1, ADDR_CTL, 32'h0);
		settle();
		chk("pwm_out plain", 32'h1, pwm_out);
		chk("adc off", 32'h0, adc_trigger);
		chk("stall off", 32'h0, tmr_stall);
	endtask : t_ctl

	task automatic t_irq;
		apb(1'b1, ADDR_IMR, 32'hffffffff);
		rdchk("imr mask", ADDR_IMR, 32'h70f);
		apb(1'b1, ADDR_IMR, 32'h0);
		pulse(2'h3, 2'h3, 1'b1);
		settle();
		rdchk("ris", ADDR_RIS, 32'h30b);
		rdchk("mis none", ADDR_MIS, 32'h0);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, ADDR_IMR, 32'h200);
		settle();
		rdchk("mis", ADDR_MIS, 32'h200);
		chk("irq", 32'h1, irq);
		apb(1'b1, ADDR_ICR, 32'h30b);
		settle();
		rdchk("ris clear", ADDR_RIS, 32'h0);
		chk("irq clear", 32'h0, irq);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", 32'h1, er);
		chk("unmapped data", 32'h0, rd);
	endtask : t_irq

	// Edge selection is only seen while the second timer is armed.
	task automatic t_capture;
		apb(1'b1, ADDR_CFG, 32'h4);
		apb(1'b1, ADDR_MODE2, 32'h3);
		apb(1'b1, ADDR_CTL, 32'h500);
		apb(1'b1, ADDR_IMR, 32'h400);
		settle();
		cap_cnt(1'b1, 0);
		cap_cnt(1'b0, 1);
		rdchk("ris cap", ADDR_RIS, 32'h400);
		chk("irq cap", 32'h1, irq);
		apb(1'b1, ADDR_CTL, 32'hd00);
		cap_cnt(1'b1, 1);
		apb(1'b1, ADDR_CTL, 32'h900);
		cap_cnt(1'b0, 0);
		apb(1'b1, ADDR_CTL, 32'hc00);
		cap_cnt(1'b1, 0);
	endtask : t_capture

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		timeout_evt = 2'h0;
		match_evt = 2'h0;
		rtc_evt = 1'b0;
		cap_pin = 2'h0;
		pwm_raw = 2'h0;
		trig_raw = 2'h0;
		debug_halt = 1'b0;
		failures = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_modes();
		t_config();
		t_ctl();
		t_irq();
		t_capture();
		end_sim();
	end

	// The run needs a few hundred cycles; the limit leaves wide room.
	initial begin
		#400000;
		failures++;
		end_sim();
	end
endmodule : test_dual_timer_mode_control_regs
